//--- hdl/fbrs_pkg.sv
// Package with constants and types shared by the flash block read-status design.
package fbrs_pkg;
    localparam int unsigned FBRS_DATA_W = 32;
    localparam int unsigned FBRS_ADDR_W = 32;
    localparam int unsigned FBRS_PAGE_W = 6;
    localparam int unsigned FBRS_WORD_W = 4;
    localparam int unsigned FBRS_CNT_W = 24;
    localparam int unsigned FBRS_CNT_LSB = 8;
    localparam int unsigned FBRS_OVER_BIT = 3;
    localparam int unsigned FBRS_RDPROT_BIT = 2;
    localparam int unsigned FBRS_WRPROT_BIT = 1;
    localparam int unsigned FBRS_LOCK_BIT = 0;
    localparam logic [1:0] FBRS_ST_OK = 2'h0;
    localparam logic [1:0] FBRS_ST_SINGLE = 2'h1;
    localparam logic [1:0] FBRS_ST_DOUBLE = 2'h2;
    localparam logic [3:0] FBRS_LAT_FAST = 4'h5;
    localparam logic [3:0] FBRS_LAT_SLOW = 4'h6;
    localparam logic [23:0] FBRS_THRESHOLD = 24'h002710;
    localparam logic [31:0] FBRS_USER_KEY = 32'h5a5aa5a5;
    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] FBRS_A_CTRL = 8'h00;
    localparam logic [7:0] FBRS_A_ADDR = 8'h04;
    localparam logic [7:0] FBRS_A_WDATA = 8'h08;
    localparam logic [7:0] FBRS_A_CMD = 8'h0c;
    localparam logic [7:0] FBRS_A_RDATA = 8'h10;
    localparam logic [7:0] FBRS_A_STAT = 8'h14;
    localparam logic [7:0] FBRS_A_KEY = 8'h18;
    localparam logic [7:0] FBRS_A_PROT = 8'h1c;
    // Command register bit positions.
    localparam int unsigned FBRS_C_READ = 0;
    localparam int unsigned FBRS_C_PAGEINFO = 1;
    localparam int unsigned FBRS_C_PROG = 2;
    localparam int unsigned FBRS_C_LOCK = 3;
    localparam int unsigned FBRS_C_UNLOCK = 4;
    localparam logic [1:0] FBRS_RESP_OK = 2'h0;
    localparam logic [1:0] FBRS_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        FBRS_IDLE = 4'h1,
        FBRS_WAIT = 4'h2,
        FBRS_PROG = 4'h4,
        FBRS_DONE = 4'h8
    } fbrs_state_t;

    // Two check bits: parity of even bits and parity of odd bits; both flip when one even and one odd bit are in error.
    function automatic logic [1:0] fbrs_check(input logic [31:0] d);
        logic [1:0] c;
        c = 2'h0;
        for (int i = 0; i < 32; i++)
        begin
            c[i % 2] = c[i % 2] ^ d[i];
        end
        return c;
    endfunction : fbrs_check
endpackage : fbrs_pkg

//--- hdl/fbrs_mem_if.sv
// Interface carrying the array memory port between the controller and its storage.
`timescale 1ns/100ps
interface fbrs_mem_if #(parameter int AW = 10, parameter int DW = 34);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : fbrs_mem_if

//--- hdl/fbrs_mem.sv
// Storage array of data words with check bits, read data registered.
`timescale 1ns/100ps
module fbrs_mem #(
    parameter int AW = 10,
    parameter int DW = 34
) (
    input wire logic aclk,
    input wire logic ce,
    fbrs_mem_if.mem port
);
    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rd_ff;

    // A plain always block lets a test bench seed bit errors into stored words.
    always @(posedge aclk)
    begin
        if (ce)
        begin
            if (port.we)
            begin
                store[port.addr] <= port.wdata;
            end
            rd_ff <= store[port.addr];
        end
    end

    assign port.rdata = rd_ff;
endmodule : fbrs_mem

//--- hdl/fbrs_top.sv
// Flash block read path with error status, page-information word, latency modes and busy.
`timescale 1ns/100ps
module fbrs_top
    import fbrs_pkg::*;
#(
    parameter int PAGES = 64,
    parameter logic [31:0] USER_KEY = FBRS_USER_KEY,
    parameter logic [23:0] THRESHOLD = FBRS_THRESHOLD
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic busy,
    output logic [1:0] read_status
);
    localparam int AW = FBRS_PAGE_W + FBRS_WORD_W;

    typedef struct packed {
        fbrs_state_t st;
        logic slow_mode;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] key;
        logic [31:0] rdata;
        logic [1:0] status;
        logic refused;
        logic [3:0] lat;
        logic pageinfo;
        logic lock_req;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wbuf;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] axrdata;
        logic [PAGES-1:0] rdprot;
        logic [PAGES-1:0] wrprot;
        logic [PAGES-1:0] locked;
        logic [PAGES-1:0][23:0] count;
    } fbrs_regs_t;

    fbrs_regs_t r_ff, nxt_r;
    fbrs_mem_if #(.AW(AW), .DW(34)) mport();

    fbrs_mem #(.AW(AW), .DW(34)) u_mem (
        .aclk(aclk),
        .ce(ce),
        .port(mport)
    );

    logic [FBRS_PAGE_W-1:0] page;
    logic key_ok;
    logic [1:0] syn;
    logic [31:0] info_word;
    assign page = r_ff.addr[FBRS_WORD_W+FBRS_PAGE_W-1:FBRS_WORD_W];
    assign key_ok = (r_ff.key == USER_KEY);
    assign syn = fbrs_check(mport.rdata[31:0]) ^ mport.rdata[33:32];

    always_comb
    begin
        info_word = '0;
        info_word[31:FBRS_CNT_LSB] = r_ff.count[page];
        info_word[FBRS_OVER_BIT] = r_ff.count[page] > THRESHOLD;
        info_word[FBRS_RDPROT_BIT] = r_ff.rdprot[page] & ~key_ok;
        info_word[FBRS_WRPROT_BIT] = r_ff.wrprot[page] & ~key_ok;
        info_word[FBRS_LOCK_BIT] = r_ff.locked[page];
    end

    assign mport.addr = r_ff.addr[AW-1:0];
    assign mport.wdata = {fbrs_check(r_ff.wdata), r_ff.wdata};
    assign mport.we = (r_ff.st == FBRS_PROG);

    logic wr_fire;
    logic [31:0] wmerged;
    always_comb
    begin
        wmerged = '0;
        for (int b = 0; b < 4; b++)
        begin
            wmerged[b*8 +: 8] = r_ff.wstrb[b] ? r_ff.wbuf[b*8 +: 8] : 8'h00;
        end
    end
    assign wr_fire = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;

    always_comb
    begin
        nxt_r = r_ff;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_r.aw_got = 1'b1;
            nxt_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_r.w_got = 1'b1;
            nxt_r.wbuf = s_axi_wdata;
            nxt_r.wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            nxt_r.bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            nxt_r.rvalid = 1'b0;
        end
        unique case (r_ff.st)
            FBRS_IDLE:
            begin
            end
            FBRS_WAIT:
            begin
                nxt_r.lat = r_ff.lat - 4'h1;
                if (r_ff.lat == 4'h1)
                begin
                    nxt_r.st = FBRS_DONE;
                    if (r_ff.pageinfo)
                    begin
                        nxt_r.rdata = info_word;
                        nxt_r.status = FBRS_ST_OK;
                    end
                    else if (syn == 2'h3)
                    begin
                        nxt_r.rdata = mport.rdata[31:0];
                        nxt_r.status = FBRS_ST_DOUBLE;
                    end
                    else if (syn != 2'h0)
                    begin
                        nxt_r.rdata = mport.rdata[31:0];
                        nxt_r.status = FBRS_ST_SINGLE;
                    end
                    else
                    begin
                        nxt_r.rdata = mport.rdata[31:0];
                        nxt_r.status = FBRS_ST_OK;
                    end
                end
            end
            FBRS_PROG:
            begin
                nxt_r.count[page] = r_ff.count[page] + 24'h000001;
                nxt_r.locked[page] = r_ff.lock_req;
                nxt_r.st = FBRS_DONE;
            end
            FBRS_DONE:
            begin
                nxt_r.st = FBRS_IDLE;
            end
        endcase
        if (wr_fire)
        begin
            nxt_r.w_got = 1'b0;
            nxt_r.aw_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = FBRS_RESP_OK;
            unique case (r_ff.awaddr)
                FBRS_A_CTRL: nxt_r.slow_mode = wmerged[0];
                FBRS_A_ADDR: nxt_r.addr = wmerged;
                FBRS_A_WDATA: nxt_r.wdata = wmerged;
                FBRS_A_KEY: nxt_r.key = wmerged;
                FBRS_A_PROT:
                begin
                    nxt_r.rdprot[page] = wmerged[FBRS_RDPROT_BIT];
                    nxt_r.wrprot[page] = wmerged[FBRS_WRPROT_BIT];
                end
                FBRS_A_CMD:
                begin
                    if (r_ff.st != FBRS_IDLE)
                    begin
                        nxt_r.bresp = FBRS_RESP_SLVERR;
                    end
                    else if (wmerged[FBRS_C_UNLOCK])
                    begin
                        nxt_r.locked[page] = 1'b0;
                        nxt_r.refused = 1'b0;
                    end
                    else if (wmerged[FBRS_C_PROG])
                    begin
                        if (r_ff.locked[page])
                        begin
                            nxt_r.refused = 1'b1;
                        end
                        else
                        begin
                            nxt_r.refused = 1'b0;
                            nxt_r.lock_req = wmerged[FBRS_C_LOCK];
                            nxt_r.st = FBRS_PROG;
                        end
                    end
                    else if (wmerged[FBRS_C_READ])
                    begin
                        nxt_r.pageinfo = wmerged[FBRS_C_PAGEINFO];
                        nxt_r.lat = r_ff.slow_mode ? FBRS_LAT_SLOW : FBRS_LAT_FAST;
                        nxt_r.st = FBRS_WAIT;
                    end
                end
                default: nxt_r.bresp = FBRS_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = FBRS_RESP_OK;
            unique case (s_axi_araddr)
                FBRS_A_CTRL: nxt_r.axrdata = {31'h0, r_ff.slow_mode};
                FBRS_A_ADDR: nxt_r.axrdata = r_ff.addr;
                FBRS_A_WDATA: nxt_r.axrdata = r_ff.wdata;
                FBRS_A_RDATA: nxt_r.axrdata = r_ff.rdata;
                FBRS_A_STAT: nxt_r.axrdata = {28'h0, r_ff.refused, r_ff.st != FBRS_IDLE, r_ff.status};
                FBRS_A_KEY: nxt_r.axrdata = {31'h0, key_ok};
                default:
                begin
                    nxt_r.axrdata = '0;
                    nxt_r.rresp = FBRS_RESP_SLVERR;
                end
            endcase
        end
        if (!aresetn)
        begin
            nxt_r = '0;
            nxt_r.st = FBRS_IDLE;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (ce || !aresetn)
        begin
            r_ff <= nxt_r;
        end
    end

    assign s_axi_awready = !r_ff.aw_got && !r_ff.bvalid;
    assign s_axi_wready = !r_ff.w_got && !r_ff.bvalid;
    assign s_axi_bvalid = r_ff.bvalid;
    assign s_axi_bresp = r_ff.bresp;
    assign s_axi_arready = !r_ff.rvalid;
    assign s_axi_rvalid = r_ff.rvalid;
    assign s_axi_rdata = r_ff.axrdata;
    assign s_axi_rresp = r_ff.rresp;
    assign busy = (r_ff.st != FBRS_IDLE);
    assign read_status = r_ff.status;

    // Checks on the read path, page-information word and program lock.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    fast_latency_a: assert property ((r_ff.st == FBRS_IDLE && nxt_r.st == FBRS_WAIT && !r_ff.slow_mode && ce)
        ##1 ce [*5] |=> r_ff.st == FBRS_DONE) else $error("Fast read did not finish in five cycles.");
    slow_latency_a: assert property ((r_ff.st == FBRS_IDLE && nxt_r.st == FBRS_WAIT && r_ff.slow_mode && ce)
        ##1 ce [*6] |=> r_ff.st == FBRS_DONE) else $error("Slow read did not finish in six cycles.");
    busy_state_a: assert property (r_ff.st == FBRS_WAIT |-> busy) else $error("Busy low during read.");
    info_reserved_a: assert property (r_ff.st == FBRS_DONE && r_ff.pageinfo |-> r_ff.rdata[7:4] == 4'h0)
        else $error("Reserved bits not zero.");
    info_status_a: assert property (r_ff.st == FBRS_DONE && r_ff.pageinfo |-> r_ff.status == FBRS_ST_OK)
        else $error("Page info read carried an error status.");
    double_err_a: assert property (r_ff.st == FBRS_WAIT && r_ff.lat == 4'h1 && !r_ff.pageinfo && syn == 2'h3 && ce
        |=> read_status == FBRS_ST_DOUBLE) else $error("Double error not reported.");
    single_err_a: assert property (r_ff.st == FBRS_WAIT && r_ff.lat == 4'h1 && !r_ff.pageinfo && ce
        && (syn == 2'h1 || syn == 2'h2) |=> read_status == FBRS_ST_SINGLE) else $error("Single error not reported.");
    clean_read_a: assert property (r_ff.st == FBRS_WAIT && r_ff.lat == 4'h1 && !r_ff.pageinfo && syn == 2'h0 && ce
        |=> read_status == FBRS_ST_OK) else $error("Clean read not reported as ok.");
    locked_refuse_a: assert property (r_ff.st == FBRS_PROG |-> !r_ff.locked[page])
        else $error("Program reached a locked page.");

    read_done_c: cover property (r_ff.st == FBRS_WAIT ##[1:6] r_ff.st == FBRS_DONE);
    prog_done_c: cover property (r_ff.st == FBRS_PROG ##1 r_ff.st == FBRS_DONE);
    refused_c: cover property ($rose(r_ff.refused));
endmodule : fbrs_top

//--- testbench/fbrs_host.sv
// AXI4-Lite master model standing for the user logic that drives the block.
`timescale 1ns/100ps
module fbrs_host (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Each handshake is judged at the falling edge, where the slave's values stand settled.
    // Released payloads are inverted so that a late sample by the slave cannot pass.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, pb, ta, tw, tb;
        @(posedge aclk);
        {pa, pw, pb} = 3'h7;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa || pw || pb)
        begin
            @(negedge aclk);
            {ta, tw, tb} = {pa & awready, pw & wready, pb & bvalid};
            if (tb) r = bresp;
            @(posedge aclk);
            if (ta) awaddr <= ~a;
            if (tw) wdata <= ~d;
            {pa, pw, pb} = {pa & !ta, pw & !tw, pb & !tb};
            {awvalid, wvalid, bready} <= {pa, pw, pb};
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic pa, pr, ta, tr;
        @(posedge aclk);
        {pa, pr} = 2'h3;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (pa || pr)
        begin
            @(negedge aclk);
            {ta, tr} = {pa & arready, pr & rvalid};
            if (tr) {d, r} = {rdata, rresp};
            @(posedge aclk);
            if (ta) araddr <= ~a;
            {pa, pr} = {pa & !ta, pr & !tr};
            {arvalid, rready} <= {pa, pr};
        end
    endtask : rd
endmodule : fbrs_host

//--- testbench/testbench.sv
// Self-checking bench for the flash block read-status logic.
`timescale 1ns/100ps
module testbench;
    import fbrs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, busy;
    logic [31:0] wdata, rdata, v, d;
    logic [1:0] bresp, rresp, read_status, rsp;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int bcnt = 0;
    int cnt [64];
    bit lk [64], rpf [64], wpf [64];
    bit keyok;
    int p, nb, nf;
    localparam int LIMIT = 4;
    always #25 aclk = ~aclk;
    fbrs_top #(.THRESHOLD(24'(LIMIT))) dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy), .read_status(read_status));
    fbrs_host host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (busy === 1'b1) bcnt <= bcnt + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        cmp(nm, {30'h0, e}, {30'h0, g});
    endtask : cmp_resp
    task automatic wreg(input logic [7:0] a, input logic [31:0] dd, input logic [1:0] er);
        host_u.wr(a, dd, rsp);
        cmp_resp("write response", er, rsp);
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
        host_u.rd(a, v, rsp);
        cmp_resp("read response", er, rsp);
        cmp(nm, e, v);
    endtask : rreg
    task automatic waitidle;
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 100)
        begin
            @(negedge aclk);
            i++;
        end
        cmp("busy clears", 32'h0, {31'h0, busy});
    endtask : waitidle
    // Runs one command and records how many cycles busy stood high.
    task automatic cmd(input logic [4:0] c);
        int b0;
        b0 = bcnt;
        wreg(FBRS_A_CMD, {27'h0, c}, FBRS_RESP_OK);
        waitidle();
        nb = bcnt - b0;
    endtask : cmd
    // A locked page keeps its count and its lock when programmed.
    task automatic prog(input int pg, input logic lock);
        cmd({1'b0, lock, 3'h4});
        if (!lk[pg])
        begin
            cnt[pg]++;
            lk[pg] = lock;
        end
    endtask : prog
    function automatic logic [31:0] info(input int pg);
        return {cnt[pg][23:0], 4'h0, cnt[pg] > LIMIT, rpf[pg] & !keyok, wpf[pg] & !keyok, lk[pg]};
    endfunction : info
    task automatic chk_info(input string nm);
        cmd(5'h03);
        rreg(FBRS_A_RDATA, info(p), FBRS_RESP_OK, nm);
    endtask : chk_info
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        void'($urandom(32'hc76b));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        cmp("reset outputs", 32'h38, {26'h0, awready, wready, arready, busy, read_status});
        $display("test reset done");
        for (int m = 0; m < 2; m++)
        begin
            p = $urandom % 64;
            d = $urandom;
            wreg(FBRS_A_CTRL, 32'(m), FBRS_RESP_OK);
            wreg(FBRS_A_ADDR, 32'(p * 16 + m), FBRS_RESP_OK);
            wreg(FBRS_A_WDATA, d, FBRS_RESP_OK);
            prog(p, 1'b0);
            cmd(5'h01);
            cmp("busy length", 32'(m ? FBRS_LAT_SLOW : FBRS_LAT_FAST) + 32'h1, 32'(nb));
            nf = (m == 0) ? nb : nb - nf;
            rreg(FBRS_A_RDATA, d, FBRS_RESP_OK, "read data");
            rreg(FBRS_A_STAT, 32'h0, FBRS_RESP_OK, "clean status");
            cmp("status port", 32'h0, {30'h0, read_status});
        end
        cmp("slow mode extra cycle", 32'h1, 32'(nf));
        $display("test read modes done");
        // Flip one check bit: one parity group disagrees, the data word is intact.
        dut_u.u_mem.store[p * 16 + 1] = dut_u.u_mem.store[p * 16 + 1] ^ 34'h100000000;
        cmd(5'h01);
        rreg(FBRS_A_RDATA, d, FBRS_RESP_OK, "single error data");
        rreg(FBRS_A_STAT, 32'h1, FBRS_RESP_OK, "single error status");
        // Restore the check bit and flip one even and one odd data bit.
        dut_u.u_mem.store[p * 16 + 1] = dut_u.u_mem.store[p * 16 + 1] ^ 34'h100000003;
        cmd(5'h01);
        rreg(FBRS_A_RDATA, d ^ 32'h3, FBRS_RESP_OK, "double error data");
        rreg(FBRS_A_STAT, 32'h2, FBRS_RESP_OK, "double error status");
        cmp("double status port", 32'h2, {30'h0, read_status});
        $display("test error status done");
        p = $urandom % 64;
        wreg(FBRS_A_ADDR, 32'(p * 16), FBRS_RESP_OK);
        repeat (3 + $urandom % 2) prog(p, 1'b0);
        chk_info("page count");
        wreg(FBRS_A_PROT, 32'h6, FBRS_RESP_OK);
        {rpf[p], wpf[p]} = 2'h3;
        chk_info("protect flags");
        wreg(FBRS_A_KEY, FBRS_USER_KEY, FBRS_RESP_OK);
        keyok = 1'b1;
        rreg(FBRS_A_KEY, 32'h1, FBRS_RESP_OK, "key match");
        chk_info("key bypass");
        wreg(FBRS_A_KEY, ~FBRS_USER_KEY, FBRS_RESP_OK);
        keyok = 1'b0;
        rreg(FBRS_A_KEY, 32'h0, FBRS_RESP_OK, "key mismatch");
        prog(p, 1'b1);
        chk_info("lock on program");
        prog(p, 1'b0);
        rreg(FBRS_A_STAT, 32'h8, FBRS_RESP_OK, "refused flag");
        chk_info("locked count");
        cmd(5'h10);
        lk[p] = 1'b0;
        prog(p, 1'b0);
        chk_info("unlocked program");
        $display("test page info done");
        wreg(FBRS_A_CMD, 32'h1, FBRS_RESP_OK);
        wreg(FBRS_A_CMD, 32'h1, FBRS_RESP_SLVERR);
        waitidle();
        rreg(8'h20, 32'h0, FBRS_RESP_SLVERR, "unmapped read");
        wreg(8'h24, $urandom, FBRS_RESP_SLVERR);
        $display("test refusals done");
        test_done();
    end
endmodule : testbench
